/* hdl/dual_port_block_ram_port.sv */
// Port sequencer and top level of the dual-port block memory.
// Assumes port clocks and pins are asynchronous to ref_clk and slower
// than half its rate; each port pin is synchronised before use.
`timescale 1ns/100ps
`default_nettype none
module port_engine import bram_pkg::*; #(
  parameter int PW = 36,
  parameter rdw_mode_t MODE = RDW_NEW,
  parameter bit CLK_RISE = 1'b1,
  parameter bit EN_HIGH = 1'b1,
  parameter bit WE_HIGH = 1'b1,
  parameter bit SR_HIGH = 1'b1,
  parameter logic [PW-1:0] init_value = '0,
  parameter logic [PW-1:0] force_value = '0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic restore,
  input wire logic port_clk,
  input wire logic gate,
  input wire logic write_strobe,
  input wire logic sync_force,
  input wire logic [addr_w(PW)-1:0] addr,
  input wire logic [data_w(PW)-1:0] write_word,
  input wire logic [check_x(PW)-1:0] write_check_bits,
  output logic [data_w(PW)-1:0] read_word,
  output logic [check_x(PW)-1:0] read_check_bits,
  cell_port_if.eng cp
);
  localparam int DW = data_w(PW);
  localparam int CW = check_w(PW);
  localparam int CWX = check_x(PW);
  localparam int AW = addr_w(PW);
  localparam int VW = 4 + AW + DW + CWX;
  localparam logic [DW-1:0] INIT_W = init_value[DW-1:0];
  localparam logic [CWX-1:0] INIT_C = CWX'(init_value >> DW);
  localparam logic [DW-1:0] FORCE_W = force_value[DW-1:0];
  localparam logic [CWX-1:0] FORCE_C = CWX'(force_value >> DW);

  logic [VW-1:0] sync1;
  logic [VW-1:0] sync2;
  logic clk_seen;
  eng_state_t state;
  eng_state_t next_state;
  logic kind_force;
  logic kind_we;
  logic [DW-1:0] wd_q;
  logic [CWX-1:0] wc_q;
  logic [DW-1:0] next_word;
  logic [CWX-1:0] next_check;

  // All pins of the port pass two flops together, so they stay aligned.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
      clk_seen <= 1'b0;
    end else begin
      sync1 <= {port_clk, gate, write_strobe, sync_force,
        addr, write_word, write_check_bits};
      sync2 <= sync1;
      clk_seen <= sync2[VW-1];
    end
  end

  // Control decode with polarity options applied.
  wire clk_now = sync2[VW-1];
  wire port_edge = CLK_RISE ? (clk_now & ~clk_seen) : (~clk_now & clk_seen);
  wire gate_on = sync2[VW-2] == EN_HIGH;
  wire we_on = sync2[VW-3] == WE_HIGH;
  wire sr_on = sync2[VW-4] == SR_HIGH;
  wire [AW-1:0] addr_s = sync2[DW+CWX +: AW];
  wire [DW-1:0] wd_s = sync2[CWX +: DW];
  wire [CWX-1:0] wc_s = sync2[CWX-1:0];
  wire fire = port_edge & gate_on;

  // Cell access: writes only with gate and strobe; force never blocks it.
  assign cp.acc = fire;
  assign cp.wr = fire & we_on;
  assign cp.dbase = DBASE_W'(addr_s) * DBASE_W'(DW);
  assign cp.cbase = CBASE_W'(addr_s) * CBASE_W'(CWX);
  assign cp.wdata = wd_s;
  assign cp.wcheck = wc_s;

  // Output selection; restore beats force, force beats read or write.
  wire load = state == ST_LOAD;
  wire load_mem = load & ~kind_force & (~kind_we | (MODE == RDW_OLD));
  wire load_new = load & ~kind_force & kind_we & (MODE == RDW_NEW);
  assign next_state = fire ? ST_LOAD : ST_IDLE;
  assign next_word = restore ? INIT_W :
    (load & kind_force) ? FORCE_W :
    load_mem ? cp.rdata :
    load_new ? wd_q : read_word;
  assign next_check = (CW == 0) ? '0 :
    restore ? INIT_C :
    (load & kind_force) ? FORCE_C :
    load_mem ? cp.rcheck :
    load_new ? wc_q : read_check_bits;

  // Sequencer and captured operation kind.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      kind_force <= 1'b0;
      kind_we <= 1'b0;
      wd_q <= '0;
      wc_q <= '0;
    end else begin
      state <= next_state;
      if (fire) begin
        kind_force <= sr_on;
        kind_we <= we_on;
        wd_q <= wd_s;
        wc_q <= wc_s;
      end
    end
  end

  // Output latches start at the power-on value.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      read_word <= INIT_W;
      read_check_bits <= (CW == 0) ? '0 : INIT_C;
    end else begin
      read_word <= next_word;
      read_check_bits <= next_check;
    end
  end

  // Outputs move only after a load or a restore.
  out_hold_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!load && !restore) |=> $stable(read_word) && $stable(read_check_bits))
    else $error("outputs changed without an operation");

  // A gated-off edge starts no load and no write.
  gate_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (port_edge && !gate_on) |-> !cp.wr ##1 state == ST_IDLE)
    else $error("inactive gate still acted");

  // A write takes the aligned word address.
  write_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (fire && we_on) |-> cp.wr && cp.dbase == DBASE_W'(addr_s) * DBASE_W'(DW))
    else $error("write not issued at its address");

  // A plain read shows the addressed cells two cycles on.
  read_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (fire && !we_on && !sr_on) ##1 !restore |=> read_word == $past(cp.rdata))
    else $error("read data not loaded");

  // Write in new-data mode shows the incoming word.
  new_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (MODE == RDW_NEW && fire && we_on && !sr_on) ##1 !restore |=> read_word == $past(wd_s, 2))
    else $error("new-data write did not show new word");

  // Write in old-data mode shows the prior content.
  old_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (MODE == RDW_OLD && fire && we_on && !sr_on) ##1 !restore |=> read_word == $past(cp.rdata))
    else $error("old-data write did not show old word");

  // Write in hold mode leaves the data output alone.
  hold_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (MODE == RDW_HOLD && fire && we_on && !sr_on) ##1 !restore |=> $stable(read_word))
    else $error("hold-mode write changed outputs");

  // Force loads the force value, check bits included.
  force_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (fire && sr_on) ##1 !restore |=> read_word == FORCE_W &&
      read_check_bits == ((CW == 0) ? CWX'(0) : FORCE_C))
    else $error("force value not loaded");

  // Restore brings back the power-on value next cycle.
  restore_init_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    restore |=> read_word == INIT_W)
    else $error("restore did not load power-on value");

  // Restore also brings back the power-on check bits.
  restore_check_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    restore |=> read_check_bits == ((CW == 0) ? CWX'(0) : INIT_C))
    else $error("restore did not load power-on check bits");

  // A plain read shows the addressed check cells as well.
  read_check_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (fire && !we_on && !sr_on) ##1 !restore |=> read_check_bits == $past(cp.rcheck))
    else $error("read check bits not loaded");

  // New-data write shows the incoming check bits.
  new_check_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (MODE == RDW_NEW && fire && we_on && !sr_on) ##1 !restore |=>
      read_check_bits == ((CW == 0) ? CWX'(0) : $past(wc_s, 2)))
    else $error("new-data write did not show new check bits");

  // Old-data write shows the prior check cells.
  old_check_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (MODE == RDW_OLD && fire && we_on && !sr_on) ##1 !restore |=> read_check_bits == $past(cp.rcheck))
    else $error("old-data write did not show old check bits");

  // Hold-mode write leaves the check outputs alone.
  hold_check_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (MODE == RDW_HOLD && fire && we_on && !sr_on) ##1 !restore |=> $stable(read_check_bits))
    else $error("hold-mode write changed check outputs");

  // A force with the gate off leaves the data output alone.
  force_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (port_edge && !gate_on && sr_on) ##1 !restore |=> $stable(read_word))
    else $error("force acted with gate off");

  // A force never blocks the write that comes with it.
  force_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (fire && sr_on && we_on) |-> cp.wr)
    else $error("force blocked a write");

  // A port without a check bus shows zero check bits.
  no_check_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (CW == 0) |-> read_check_bits == CWX'(0))
    else $error("check bits shown on a port without check bus");

endmodule : port_engine

module dual_port_block_ram_port import bram_pkg::*; #(
  parameter int PORT_W_A = 36,
  parameter int PORT_W_B = 36,
  parameter rdw_mode_t MODE_A = RDW_NEW,
  parameter rdw_mode_t MODE_B = RDW_NEW,
  parameter bit CLK_RISE_A = 1'b1,
  parameter bit CLK_RISE_B = 1'b1,
  parameter bit EN_HIGH_A = 1'b1,
  parameter bit EN_HIGH_B = 1'b1,
  parameter bit WE_HIGH_A = 1'b1,
  parameter bit WE_HIGH_B = 1'b1,
  parameter bit SR_HIGH_A = 1'b1,
  parameter bit SR_HIGH_B = 1'b1,
  parameter logic [PORT_W_A-1:0] init_value_a = '0,
  parameter logic [PORT_W_B-1:0] init_value_b = '0,
  parameter logic [PORT_W_A-1:0] force_value_a = '0,
  parameter logic [PORT_W_B-1:0] force_value_b = '0,
  parameter logic [PRELOAD_WORDS-1:0][PRELOAD_BITS-1:0] preload_contents = '0,
  parameter logic [PRELOAD_CHECK_WORDS-1:0][PRELOAD_BITS-1:0] preload_check_contents = '0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic global_async_restore,
  input wire logic port_clk_a,
  input wire logic gate_a,
  input wire logic write_strobe_a,
  input wire logic out_latch_sync_force_a,
  input wire logic [addr_w(PORT_W_A)-1:0] addr_a,
  input wire logic [data_w(PORT_W_A)-1:0] write_word_a,
  input wire logic [check_x(PORT_W_A)-1:0] write_check_bits_a,
  output logic [data_w(PORT_W_A)-1:0] read_word_a,
  output logic [check_x(PORT_W_A)-1:0] read_check_bits_a,
  input wire logic port_clk_b,
  input wire logic gate_b,
  input wire logic write_strobe_b,
  input wire logic out_latch_sync_force_b,
  input wire logic [addr_w(PORT_W_B)-1:0] addr_b,
  input wire logic [data_w(PORT_W_B)-1:0] write_word_b,
  input wire logic [check_x(PORT_W_B)-1:0] write_check_bits_b,
  output logic [data_w(PORT_W_B)-1:0] read_word_b,
  output logic [check_x(PORT_W_B)-1:0] read_check_bits_b
);
  logic restore_s1;
  logic restore_s2;

  // Restore pin is asynchronous, so it is brought in through two flops.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      restore_s1 <= 1'b0;
      restore_s2 <= 1'b0;
    end else begin
      restore_s1 <= global_async_restore;
      restore_s2 <= restore_s1;
    end
  end

  // One access channel per port towards the shared array.
  cell_port_if #(.DW(data_w(PORT_W_A)), .CWX(check_x(PORT_W_A))) chan_a ();
  cell_port_if #(.DW(data_w(PORT_W_B)), .CWX(check_x(PORT_W_B))) chan_b ();

  // Two independent sequencers share one array.
  port_engine #(
    .PW(PORT_W_A),
    .MODE(MODE_A),
    .CLK_RISE(CLK_RISE_A),
    .EN_HIGH(EN_HIGH_A),
    .WE_HIGH(WE_HIGH_A),
    .SR_HIGH(SR_HIGH_A),
    .init_value(init_value_a),
    .force_value(force_value_a)
  ) eng_a (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .restore(restore_s2),
    .port_clk(port_clk_a),
    .gate(gate_a),
    .write_strobe(write_strobe_a),
    .sync_force(out_latch_sync_force_a),
    .addr(addr_a),
    .write_word(write_word_a),
    .write_check_bits(write_check_bits_a),
    .read_word(read_word_a),
    .read_check_bits(read_check_bits_a),
    .cp(chan_a.eng)
  );

  port_engine #(
    .PW(PORT_W_B),
    .MODE(MODE_B),
    .CLK_RISE(CLK_RISE_B),
    .EN_HIGH(EN_HIGH_B),
    .WE_HIGH(WE_HIGH_B),
    .SR_HIGH(SR_HIGH_B),
    .init_value(init_value_b),
    .force_value(force_value_b)
  ) eng_b (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .restore(restore_s2),
    .port_clk(port_clk_b),
    .gate(gate_b),
    .write_strobe(write_strobe_b),
    .sync_force(out_latch_sync_force_b),
    .addr(addr_b),
    .write_word(write_word_b),
    .write_check_bits(write_check_bits_b),
    .read_word(read_word_b),
    .read_check_bits(read_check_bits_b),
    .cp(chan_b.eng)
  );

  // The array holds the cells and their preload contents.
  cell_array #(
    .PW_A(PORT_W_A),
    .PW_B(PORT_W_B),
    .preload_contents(preload_contents),
    .preload_check_contents(preload_check_contents)
  ) cells (
    .ref_clk(ref_clk),
    .pa(chan_a.mem),
    .pb(chan_b.mem)
  );

endmodule : dual_port_block_ram_port
`default_nettype wire

/* hdl/bram_pkg.sv */
// Constants, widths and modes of the dual-port block memory.
// Assumes a single ref_clk domain; users include it by import.
// Functional notes
// - Two ports, independent clocks, one cell array.
// - Inactive gate: no write, outputs hold.
// - Gate and strobe active: store data, check.
// - Gate without strobe: load addressed cells out.
// - Write shows new data or old data.
// - Hold mode keeps last read during writes.
// - Force loads latches with force value.
// - Force never touches cells nor other port.
// - Force acts only with gate active.
// - Force value per port, port wide.
// - Port width sets depth and address width.
// - Data plus check bus equals width.
// - Outputs hold until next port operation.
// - Clock, gate, strobe, force polarity options.
// - Restore loads power-on value, cells untouched.
// - Access covers cells addr*width upward.
// - Sixty-four 256-bit data preload words, zero default.
// - Preload word n covers cells n*256 upward.
// - Eight 256-bit check preload words, zero default.
// - Per-port write mode, default new data.
// - Cross-port read sees old content.
// - Power-on value port wide, default zero.
// - Force value port wide, default zero.
package bram_pkg;

  localparam int DATA_CELLS = 16384;
  localparam int CHECK_CELLS = 2048;
  localparam int PRELOAD_BITS = 256;
  localparam int PRELOAD_WORDS = 64;
  localparam int PRELOAD_CHECK_WORDS = 8;
  localparam int MAX_PORT_W = 36;
  localparam int DBASE_W = 14;
  localparam int CBASE_W = 11;

  // Read-during-write behaviour of a port.
  typedef enum logic [1:0] {
    RDW_NEW = 2'h0,
    RDW_OLD = 2'h1,
    RDW_HOLD = 2'h3
  } rdw_mode_t;

  // Port sequencer: idle, then one cycle loading the output latches.
  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_LOAD = 1'h1
  } eng_state_t;

  // Data bus width for a port width.
  function automatic int data_w(input int pw);
    case (pw)
      9: data_w = 8;
      18: data_w = 16;
      36: data_w = 32;
      default: data_w = pw;
    endcase
  endfunction : data_w

  // Check bus width for a port width, zero where there is none.
  function automatic int check_w(input int pw);
    case (pw)
      9: check_w = 1;
      18: check_w = 2;
      36: check_w = 4;
      default: check_w = 0;
    endcase
  endfunction : check_w

  // Carried check width, never below one bit.
  function automatic int check_x(input int pw);
    check_x = (check_w(pw) > 0) ? check_w(pw) : 1;
  endfunction : check_x

  // Address width for a port width.
  function automatic int addr_w(input int pw);
    case (pw)
      1: addr_w = 14;
      2: addr_w = 13;
      4: addr_w = 12;
      9: addr_w = 11;
      18: addr_w = 10;
      default: addr_w = 9;
    endcase
  endfunction : addr_w

endpackage : bram_pkg

/* hdl/cell_port_if.sv */
// Access channel between one port sequencer and the cell array.
// Assumes both ends run on ref_clk.
`timescale 1ns/100ps
`default_nettype none
interface cell_port_if #(
  parameter int DW = 32,
  parameter int CWX = 4
);
  logic acc;
  logic wr;
  logic [13:0] dbase;
  logic [10:0] cbase;
  logic [DW-1:0] wdata;
  logic [CWX-1:0] wcheck;
  logic [DW-1:0] rdata;
  logic [CWX-1:0] rcheck;

  modport eng (output acc, wr, dbase, cbase, wdata, wcheck, input rdata, rcheck);
  modport mem (input acc, wr, dbase, cbase, wdata, wcheck, output rdata, rcheck);
endinterface : cell_port_if
`default_nettype wire

/* hdl/cell_array.sv */
// Shared data and check cell array with two access channels.
// Assumes channels present at most one access per cycle each.
`timescale 1ns/100ps
`default_nettype none
module cell_array import bram_pkg::*; #(
  parameter int PW_A = 36,
  parameter int PW_B = 36,
  parameter logic [PRELOAD_WORDS-1:0][PRELOAD_BITS-1:0] preload_contents = '0,
  parameter logic [PRELOAD_CHECK_WORDS-1:0][PRELOAD_BITS-1:0] preload_check_contents = '0
) (
  input wire logic ref_clk,
  cell_port_if.mem pa,
  cell_port_if.mem pb
);
  localparam int DWA = data_w(PW_A);
  localparam int DWB = data_w(PW_B);
  localparam int CWA = check_x(PW_A);
  localparam int CWB = check_x(PW_B);
  localparam bit HCA = check_w(PW_A) > 0;
  localparam bit HCB = check_w(PW_B) > 0;

  // Packed preload words put word n at cells n*256 upward; no reset clears them.
  logic [DATA_CELLS-1:0] dcells = preload_contents;
  logic [CHECK_CELLS-1:0] ccells = preload_check_contents;

  // Reads capture the old content; port B's write lands last on overlap.
  always_ff @(posedge ref_clk) begin
    if (pa.acc) begin
      pa.rdata <= dcells[pa.dbase +: DWA];
      pa.rcheck <= HCA ? ccells[pa.cbase +: CWA] : '0;
    end
    if (pb.acc) begin
      pb.rdata <= dcells[pb.dbase +: DWB];
      pb.rcheck <= HCB ? ccells[pb.cbase +: CWB] : '0;
    end
    if (pa.wr) begin
      dcells[pa.dbase +: DWA] <= pa.wdata;
      if (HCA) begin
        ccells[pa.cbase +: CWA] <= pa.wcheck;
      end
    end
    if (pb.wr) begin
      dcells[pb.dbase +: DWB] <= pb.wdata;
      if (HCB) begin
        ccells[pb.cbase +: CWB] <= pb.wcheck;
      end
    end
  end

  // Flags two writes in one cycle whose cell ranges overlap; a spare bit avoids wrap.
  write_clash_a: assert property (@(posedge ref_clk)
    !(pa.wr && pb.wr && (15'(pa.dbase) < 15'(pb.dbase) + 15'(DWB))
      && (15'(pb.dbase) < 15'(pa.dbase) + 15'(DWA))))
    else $error("both ports wrote overlapping cells");

endmodule : cell_array
`default_nettype wire

/* tb/port_user.sv */
// Behavioural user logic that drives one port of the dual-port memory.
// Assumes ref_clk is the system clock; the port clock is made from it.
`timescale 1ns/100ps
`default_nettype none
module port_user import bram_pkg::*; #(
  parameter int PW = 36
) (
  input wire logic ref_clk,
  output logic port_clk,
  output logic gate,
  output logic write_strobe,
  output logic sync_force,
  output logic [addr_w(PW)-1:0] addr,
  output logic [data_w(PW)-1:0] write_word,
  output logic [check_x(PW)-1:0] write_check_bits
);
  // Control lines rest at zero and address and data lines at one, the port clock low so reset release sees no edge.
  initial begin
    port_clk = 1'b0;
    gate = 1'b0;
    write_strobe = 1'b0;
    sync_force = 1'b0;
    addr = '1;
    write_word = '1;
    write_check_bits = '1;
  end

  // One access: set up a cycle early, two-cycle high phase, two-cycle low phase.
  task automatic op(input logic g, input logic w, input logic f,
      input logic [addr_w(PW)-1:0] a, input logic [data_w(PW)-1:0] d,
      input logic [check_x(PW)-1:0] c);
    @(negedge ref_clk);
    gate = g;
    write_strobe = w;
    sync_force = f;
    addr = a;
    write_word = d;
    write_check_bits = c;
    @(negedge ref_clk);
    port_clk = 1'b1;
    repeat (2) @(negedge ref_clk);
    port_clk = 1'b0;
    // Released control lines drop to zero; address and data show the inverse of their last value, not a stale copy.
    gate = 1'b0;
    write_strobe = 1'b0;
    sync_force = 1'b0;
    addr = ~a;
    write_word = ~d;
    write_check_bits = ~c;
    repeat (2) @(negedge ref_clk);
  endtask : op
endmodule : port_user
`default_nettype wire

/* tb/dual_port_block_ram_port_tb.sv */
// Self-checking bench: port A is 36 wide in old-data mode, port B 9 wide in new-data mode.
// Assumes the design package and the port_user model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module dual_port_block_ram_port_tb import bram_pkg::*;;
  localparam logic [35:0] INIT_A = 36'ha12345678;
  localparam logic [35:0] FORCE_A = 36'h59abcdef0;
  localparam logic [8:0] INIT_B = 9'h1a5;
  localparam logic [8:0] FORCE_B = 9'h0c3;
  localparam logic [35:0] IB = {3'h0, INIT_B[8], 24'h0, INIT_B[7:0]};
  localparam logic [35:0] FB = {3'h0, FORCE_B[8], 24'h0, FORCE_B[7:0]};
  localparam logic [16383:0] PRE = {{8{32'hc3a50f96}}, {15872{1'b0}}, {8{32'h13579bdf}}};
  localparam logic [2047:0] PREC = {{1792{1'b0}}, 256'h5a3c};
  logic ref_clk = 1'b0;
  logic rst_b;
  logic global_async_restore;
  logic port_clk_a, gate_a, write_strobe_a, out_latch_sync_force_a;
  logic port_clk_b, gate_b, write_strobe_b, out_latch_sync_force_b;
  logic [8:0] addr_a;
  logic [10:0] addr_b;
  logic [31:0] write_word_a, read_word_a;
  logic [7:0] write_word_b, read_word_b;
  logic [3:0] write_check_bits_a, read_check_bits_a;
  logic [0:0] write_check_bits_b, read_check_bits_b;
  logic [16383:0] dmem;
  logic [2047:0] cmem;
  logic [35:0] pred [2];
  logic [15:0] seed;
  logic [31:0] r1, r2;
  int fail_count = 0;
  int num_checks = 0;

  // The clock toggles every half period of 5 ns.
  always #5 ref_clk = ~ref_clk;

  dual_port_block_ram_port #(.PORT_W_A(36), .PORT_W_B(9), .MODE_A(RDW_OLD), .MODE_B(RDW_NEW),
    .init_value_a(INIT_A), .init_value_b(INIT_B), .force_value_a(FORCE_A),
    .force_value_b(FORCE_B), .preload_contents(PRE), .preload_check_contents(PREC))
  u_dual_port_block_ram_port (.ref_clk(ref_clk), .rst_b(rst_b),
    .global_async_restore(global_async_restore), .port_clk_a(port_clk_a), .gate_a(gate_a),
    .write_strobe_a(write_strobe_a), .out_latch_sync_force_a(out_latch_sync_force_a),
    .addr_a(addr_a), .write_word_a(write_word_a), .write_check_bits_a(write_check_bits_a),
    .read_word_a(read_word_a), .read_check_bits_a(read_check_bits_a),
    .port_clk_b(port_clk_b), .gate_b(gate_b), .write_strobe_b(write_strobe_b),
    .out_latch_sync_force_b(out_latch_sync_force_b), .addr_b(addr_b),
    .write_word_b(write_word_b), .write_check_bits_b(write_check_bits_b),
    .read_word_b(read_word_b), .read_check_bits_b(read_check_bits_b));

  port_user #(.PW(36)) u_port_user_a (.ref_clk(ref_clk), .port_clk(port_clk_a), .gate(gate_a),
    .write_strobe(write_strobe_a), .sync_force(out_latch_sync_force_a), .addr(addr_a),
    .write_word(write_word_a), .write_check_bits(write_check_bits_a));
  port_user #(.PW(9)) u_port_user_b (.ref_clk(ref_clk), .port_clk(port_clk_b), .gate(gate_b),
    .write_strobe(write_strobe_b), .sync_force(out_latch_sync_force_b), .addr(addr_b),
    .write_word(write_word_b), .write_check_bits(write_check_bits_b));

  // Pseudo-random source: 16-bit shift register, two steps per 32-bit value.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction : lfsr

  task automatic next_rand(output logic [31:0] v);
    v[15:0] = seed;
    seed = lfsr(seed);
    v[31:16] = seed;
    seed = lfsr(seed);
  endtask : next_rand

  // Shadow word as {check, data}: word a of width dw spans cells a*dw upward.
  function automatic logic [35:0] cells(input int dw, input int cw, input int a);
    logic [35:0] r;
    r = '0;
    for (int i = 0; i < dw; i++) r[i] = dmem[a * dw + i];
    for (int i = 0; i < cw; i++) r[32 + i] = cmem[a * cw + i];
    return r;
  endfunction : cells

  // Compare tasks, one for data words and one for check bits.
  task automatic check_d(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: data out %h, expected %h", $time, got, exp);
    end
  endtask : check_d

  task automatic check_c(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: check out %h, expected %h", $time, got, exp);
    end
  endtask : check_c

  task automatic cmp_out(input bit pb);
    logic [31:0] gd;
    logic [3:0] gc;
    gd = pb ? {24'h0, read_word_b} : read_word_a;
    gc = pb ? {3'h0, read_check_bits_b} : read_check_bits_a;
    check_d(gd, pred[pb][31:0]);
    check_c(gc, pred[pb][35:32]);
  endtask : cmp_out

  // One access on port A (pb 0) or B (pb 1), predicting outputs and cells.
  task automatic access(input bit pb, input logic g, input logic w, input logic f, input int a,
      input logic [31:0] d, input logic [3:0] c);
    int dw;
    int cw;
    logic [35:0] old;
    dw = pb ? 8 : 32;
    cw = pb ? 1 : 4;
    old = cells(dw, cw, a);
    if (pb) u_port_user_b.op(g, w, f, a[10:0], d[7:0], c[0:0]);
    else u_port_user_a.op(g, w, f, a[8:0], d, c);
    if (g && w) begin
      for (int i = 0; i < dw; i++) dmem[a * dw + i] = d[i];
      for (int i = 0; i < cw; i++) cmem[a * cw + i] = c[i];
    end
    if (g && f) pred[pb] = pb ? FB : FORCE_A;
    else if (g && (!w || !pb)) pred[pb] = old;
    else if (g) pred[pb] = {3'h0, c[0], 24'h0, d[7:0]};
    cmp_out(pb);
  endtask : access

  // Pulse the global restore and expect power-on values on both ports.
  task automatic restore;
    @(negedge ref_clk);
    global_async_restore = 1'b1;
    repeat (2) @(negedge ref_clk);
    global_async_restore = 1'b0;
    repeat (4) @(negedge ref_clk);
    pred[0] = INIT_A;
    pred[1] = IB;
    cmp_out(0);
    cmp_out(1);
  endtask : restore

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence: reset, preload reads, random paired traffic, corner cases.
  initial begin
    rst_b = 1'b0;
    global_async_restore = 1'b0;
    dmem = PRE;
    cmem = PREC;
    pred[0] = INIT_A;
    pred[1] = IB;
    seed = 16'hc9ef;
    repeat (16) @(negedge ref_clk);
    cmp_out(0);
    cmp_out(1);
    rst_b = 1'b1;
    repeat (3) @(negedge ref_clk);
    access(0, 1, 0, 0, 0, '1, '1);
    access(0, 1, 0, 0, 511, '1, '1);
    access(1, 1, 0, 0, 2047, '1, '1);
    for (int n = 0; n < 40; n++) begin
      next_rand(r1);
      next_rand(r2);
      // Port A stays in cells below 8192 and port B above, so they never collide.
      fork
        access(0, r2[30] | r2[29], 1, 0, r1[7:0], r2, r1[31:28]);
        access(1, 1, 1, 0, 1024 + r1[17:8], r1, r2[3:0]);
      join
      access(1, 1, 0, 0, {r1[7:0], r2[9:8]}, '0, '0);
      access(0, 1, 0, 0, 256 + r1[17:10], '0, '0);
    end
    access(0, 0, 1, 0, 3, 32'hdeadbeef, 4'h5);
    access(0, 1, 0, 0, 3, '1, '1);
    access(0, 0, 0, 1, 3, '1, '1);
    access(0, 1, 0, 1, 3, '1, '1);
    repeat (12) @(negedge ref_clk);
    cmp_out(0);
    // Port A forces during its own write while port B writes into A's word 6.
    fork
      access(0, 1, 1, 1, 5, 32'h0badf00d, 4'h9);
      access(1, 1, 1, 0, 24, 32'h77, 4'h1);
    join
    access(0, 1, 0, 0, 5, '1, '1);
    access(0, 1, 0, 0, 6, '1, '1);
    access(1, 1, 0, 1, 7, '1, '1);
    // Port B reads a byte of word 9 while old-data port A rewrites it.
    fork
      access(0, 1, 1, 0, 9, 32'h2468ace0, 4'h3);
      access(1, 1, 0, 0, 36, '1, '1);
    join
    restore();
    access(1, 1, 0, 0, 24, '1, '1);
    give_verdict();
  end

  // Watchdog: the sequence needs about 840 cycles, so 6,000 cycles means a hang.
  initial begin
    #60000;
    fail_count++;
    give_verdict();
  end
endmodule : dual_port_block_ram_port_tb
`default_nettype wire
